// >>> logic/spiss_defs.vh
// register map, field positions and reset values of the serial select/status block
`ifndef SPISS_DEFS_VH
`define SPISS_DEFS_VH
// ----------------------------------------------------------------------
// register byte offsets on the bus
// ----------------------------------------------------------------------
`define SPISS_OFS_CSR    8'h00
`define SPISS_OFS_DR     8'h04
`define SPISS_OFS_CR     8'h08
// ----------------------------------------------------------------------
// serial_control_status fields
// ----------------------------------------------------------------------
`define SPISS_CSR_TCF    7
`define SPISS_CSR_COLL   6
`define SPISS_CSR_OVRN   5
`define SPISS_CSR_MFLT   4
`define SPISS_CSR_ODIS   2
`define SPISS_CSR_SRCSW  1
`define SPISS_CSR_SWLVL  0
`define SPISS_CSR_RST    8'h00
`define SPISS_CTL_RST    3'h0
// ----------------------------------------------------------------------
// serial_control_reg fields
// ----------------------------------------------------------------------
`define SPISS_CR_IRQEN   7
`define SPISS_CR_EN      6
`define SPISS_CR_MSTR    4
`define SPISS_CR_CPOL    3
`define SPISS_CR_CPHA    2
`define SPISS_CR_DIV_HI  1
`define SPISS_CR_DIV_LO  0
`define SPISS_CR_RST     8'h00
`define SPISS_DR_RST     8'h00
// ----------------------------------------------------------------------
// framing counts
// ----------------------------------------------------------------------
`define SPISS_LAST_EDGE  4'hf
`define SPISS_HALF_BASE  5'h02
`define SPISS_RD_ZERO    32'h0000_0000
`endif

// >>> logic/spiss_sync.v
// three-stage pin synchroniser with agreement filter and change strobe
`timescale 1ns/1ps
`default_nettype none
module spiss_sync #(
    parameter W = 4                      // number of pins
) (
    input  wire         pclk,            // block clock
    input  wire         presetn,         // async reset, active low
    input  wire [W-1:0] pin_i,           // raw pins from outside
    input  wire [W-1:0] rst_lvl,         // constant, no effect: reset loads all ones
    output wire [W-1:0] lvl,             // accepted level
    output wire [W-1:0] chg              // accepted change this cycle
);
    reg [W-1:0] s1_r;                    // first stage, read by s2 only
    reg [W-1:0] s2_r;                    // second stage
    reg [W-1:0] s3_r;                    // third stage
    reg [W-1:0] hold_r;                  // last accepted level
    // ------------------------------------------------------------------
    // sampling chain
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r   <= {W{1'b1}};
            s2_r   <= {W{1'b1}};
            s3_r   <= {W{1'b1}};
            hold_r <= {W{1'b1}};
        end else begin
            s1_r   <= pin_i;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            hold_r <= lvl;
        end
    end
    // a change counts once stages two and three agree; used without a
    // further flop so edge detection costs only three cycles of latency
    assign lvl = ((s2_r ^ s3_r) == {W{1'b0}}) ? s3_r : (hold_r & ~rst_lvl | hold_r);
    assign chg = lvl ^ hold_r;
endmodule // spiss_sync
`default_nettype wire

// >>> logic/spiss_top.v
// serial interface slave-select, status flags and data register behind apb
//
// Summary of operation
// - software select drives internal level, pin freed
// - byte done sets transfer flag, may interrupt
// - transfer flag cleared by status then data
// - data writes ignored while flag until status read
// - data write during transfer sets collision flag
// - byte done with flag set raises overrun
// - status read clears overrun
// - select low in master sets fault flag
// - fault cleared by status access, control write
// - output disable bit gates serial data output
// - management bit picks pin or software level
// - software level: zero selects, one deselects
// - bit three reads zero, status resets zero
// - master data write starts a byte
// - last edge copies shift byte to buffer; code skips the copy while the transfer flag is still set
// - write loads shifter, read returns buffer
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "spiss_defs.vh"
module spiss_top (
    input  wire        pclk,             // bus clock, 50 mhz
    input  wire        presetn,          // async reset, active low
    input  wire        psel,             // apb select
    input  wire        penable,          // apb access phase
    input  wire        pwrite,           // apb direction
    input  wire [7:0]  paddr,            // apb byte address
    input  wire [31:0] pwdata,           // apb write data
    input  wire [3:0]  pstrb,            // apb byte strobes
    output reg  [31:0] prdata,           // apb read data
    output reg         pready,           // apb ready
    output reg         pslverr,          // apb error, unmapped address
    input  wire        sck_i,            // serial clock pin in
    output reg         sck_o,            // serial clock pin out
    output reg         sck_oe,           // serial clock drive enable
    input  wire        mosi_i,           // master-out pin in
    output reg         mosi_o,           // master-out pin out
    output reg         mosi_oe,          // master-out drive enable
    input  wire        miso_i,           // master-in pin in
    output reg         miso_o,           // master-in pin out
    output reg         miso_oe,          // master-in drive enable
    input  wire        ss_n_i,           // slave-select pin, active low
    output reg         irq               // interrupt request, level
);
    // ------------------------------------------------------------------
    // local types and helpers
    // ------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b01;    // master waiting for a write
    localparam [1:0] ST_RUN  = 2'b10;    // master clocking a byte

    // half period of the generated clock in bus cycles
    function [4:0] spiss_half;
        input [1:0] div;
        begin
            spiss_half = `SPISS_HALF_BASE << div;
        end
    endfunction

    reg  [7:0] cr_r;                     // serial_control_reg
    reg  [2:0] ctl_r;                    // writable status bits 2..0
    reg        tcf_r;                    // transfer_complete_flag
    reg        coll_r;                   // write_collision_flag
    reg        ovrn_r;                   // overrun_flag
    reg        mflt_r;                   // master_fault_flag
    reg        touch_r;                  // status accessed since byte done
    reg        rdtouch_r;                // status read since byte done
    reg        mseen_r;                  // status accessed while fault set
    reg  [7:0] rx_buf_r;                 // receive buffer seen by reads
    reg  [7:0] tx_sh_r;                  // transmit shifter
    reg  [7:0] rx_sh_r;                  // receive shifter
    reg  [7:0] tx_sh_nxt;                // next transmit shifter
    reg  [7:0] rx_sh_nxt;                // next receive shifter
    reg  [1:0] m_state_r;                // master state
    reg  [4:0] div_cnt_r;                // clock divider count
    reg  [3:0] half_cnt_r;               // master edge index
    reg  [3:0] slv_cnt_r;                // slave edge index
    reg  [7:0] rd_mux;                   // read data selection

    wire [3:0] pin_lvl;                  // filtered pin levels
    wire [3:0] pin_chg;                  // filtered pin changes

    // ------------------------------------------------------------------
    // pin synchroniser: sck, mosi, miso, ss_n
    // ------------------------------------------------------------------
    spiss_sync #(
        .W       (4)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_i   ({sck_i, mosi_i, miso_i, ss_n_i}),
        .rst_lvl (4'hf),
        .lvl     (pin_lvl),
        .chg     (pin_chg)
    );
    wire sck_lvl = pin_lvl[3];           // filtered serial clock
    wire sck_chg = pin_chg[3];           // serial clock edge
    wire mosi_lvl = pin_lvl[2];          // filtered master-out
    wire miso_lvl = pin_lvl[1];          // filtered master-in
    wire ss_pin = pin_lvl[0];            // filtered select pin

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire setup   = psel & ~penable;      // setup phase of a transfer
    wire acc     = psel & penable & pready; // completing edge
    wire hit_csr = (paddr == `SPISS_OFS_CSR);
    wire hit_dr  = (paddr == `SPISS_OFS_DR);
    wire hit_cr  = (paddr == `SPISS_OFS_CR);
    wire hit_any = hit_csr | hit_dr | hit_cr;
    wire wr_acc  = acc & pwrite & pstrb[0]; // only lane 0 holds data
    wire csr_acc = acc & hit_csr;        // any status access
    wire csr_rd  = acc & ~pwrite & hit_csr;
    wire csr_wr  = wr_acc & hit_csr;
    wire dr_acc  = acc & hit_dr & (~pwrite | pstrb[0]);
    wire dr_wr   = wr_acc & hit_dr;
    wire cr_wr   = wr_acc & hit_cr;

    // ------------------------------------------------------------------
    // mode and select decode
    // ------------------------------------------------------------------
    wire en      = cr_r[`SPISS_CR_EN];
    wire mstr    = cr_r[`SPISS_CR_MSTR];
    wire cpol    = cr_r[`SPISS_CR_CPOL];
    wire cpha    = cr_r[`SPISS_CR_CPHA];
    wire odis    = ctl_r[`SPISS_CSR_ODIS];
    // pin is ignored entirely under software management
    wire ss_int  = ctl_r[`SPISS_CSR_SRCSW] ? ctl_r[`SPISS_CSR_SWLVL] : ss_pin;
    wire m_on    = en & mstr;
    // master must see a high internal level; low is a fault
    wire fault_ev = m_on & ~ss_int;
    wire m_run   = m_state_r[1];
    wire s_act   = en & ~mstr & ~ss_int; // slave selected

    // ------------------------------------------------------------------
    // clock edge events of both engines
    // ------------------------------------------------------------------
    wire tick    = m_run & (div_cnt_r == spiss_half(cr_r[1:0]) - 5'h01);
    wire m_lead  = tick & ~half_cnt_r[0];
    wire m_trail = tick & half_cnt_r[0];
    wire rise    = sck_chg & sck_lvl;
    wire fall    = sck_chg & ~sck_lvl;
    wire s_lead  = s_act & (cpol ? fall : rise);
    wire s_trail = s_act & (cpol ? rise : fall);
    wire lead_ev  = m_lead | s_lead;
    wire trail_ev = m_trail | s_trail;
    wire [3:0] idx = mstr ? half_cnt_r : slv_cnt_r;
    wire done_ev  = trail_ev & (idx == `SPISS_LAST_EDGE);
    // phase 0 samples on the leading edge, phase 1 on the trailing
    wire samp_ev  = cpha ? trail_ev : lead_ev;
    wire shift_ev = cpha ? (lead_ev & (idx != 4'h0)) : trail_ev;
    wire in_bit   = mstr ? miso_lvl : mosi_lvl;

    // phase 0 slave counts as busy for the whole selected window, so a
    // write while select stays low collides; phase 1 only mid-byte
    wire busy = m_run | (~mstr & ((slv_cnt_r != 4'h0) | (~cpha & s_act)));
    // write blocked while a completed byte waits for its status read
    wire wr_ok   = ~tcf_r | rdtouch_r;
    wire load    = dr_wr & wr_ok & ~busy;
    wire start   = load & m_on;

    // ------------------------------------------------------------------
    // apb answer: ready one cycle after setup, zero wait states
    // ------------------------------------------------------------------
    always @* begin
        case (1'b1)
            hit_csr: rd_mux = {tcf_r, coll_r, ovrn_r, mflt_r, 1'b0, ctl_r};
            hit_dr:  rd_mux = rx_buf_r;
            hit_cr:  rd_mux = cr_r;
            default: rd_mux = 8'h00;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= `SPISS_RD_ZERO;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~hit_any;
            if (setup & ~pwrite) begin
                prdata <= {24'h00_0000, rd_mux};
            end else if (setup) begin
                prdata <= `SPISS_RD_ZERO;
            end
        end
    end

    // ------------------------------------------------------------------
    // control register and writable status bits
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cr_r  <= `SPISS_CR_RST;
            ctl_r <= `SPISS_CTL_RST;
        end else begin
            if (cr_wr) begin
                cr_r <= pwdata[7:0];
            end
            // a fault drops master mode, even over a same-cycle write
            if (fault_ev) begin
                cr_r[`SPISS_CR_MSTR] <= 1'b0;
            end
            // flag positions ignore written values
            if (csr_wr) begin
                ctl_r <= pwdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // status flags and their clear sequences; set wins over clear
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcf_r     <= 1'b0;
            coll_r    <= 1'b0;
            ovrn_r    <= 1'b0;
            mflt_r    <= 1'b0;
            touch_r   <= 1'b0;
            rdtouch_r <= 1'b0;
            mseen_r   <= 1'b0;
        end else begin
            // status then data access clears completion and collision
            if (done_ev) begin
                tcf_r     <= 1'b1;
                touch_r   <= 1'b0;
                rdtouch_r <= 1'b0;
            end else begin
                if (dr_acc & touch_r) begin
                    tcf_r     <= 1'b0;
                    touch_r   <= 1'b0;
                    rdtouch_r <= 1'b0;
                end else begin
                    if (csr_acc) begin
                        touch_r <= 1'b1;
                    end
                    if (csr_rd) begin
                        rdtouch_r <= 1'b1;
                    end
                end
            end
            if (dr_wr & wr_ok & busy) begin
                coll_r <= 1'b1;
            end else if (dr_acc & touch_r) begin
                coll_r <= 1'b0;
            end
            // overrun: a byte lands while the previous one is unclaimed
            if (done_ev & tcf_r) begin
                ovrn_r <= 1'b1;
            end else if (csr_rd) begin
                ovrn_r <= 1'b0;
            end
            if (fault_ev) begin
                mflt_r <= 1'b1;
            end else if (cr_wr & mseen_r) begin
                mflt_r  <= 1'b0;
                mseen_r <= 1'b0;
            end else if (csr_acc & mflt_r) begin
                mseen_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // master clock generator
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_state_r  <= ST_IDLE;
            div_cnt_r  <= 5'h00;
            half_cnt_r <= 4'h0;
            sck_o      <= 1'b0;
        end else begin
            case (m_state_r)
                ST_IDLE: begin
                    sck_o      <= cpol;  // idle level follows polarity
                    div_cnt_r  <= 5'h00;
                    half_cnt_r <= 4'h0;
                    if (start) begin
                        m_state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (fault_ev | ~m_on) begin
                        m_state_r <= ST_IDLE; // abort, byte is lost
                    end else if (tick) begin
                        div_cnt_r  <= 5'h00;
                        sck_o      <= ~sck_o;
                        half_cnt_r <= half_cnt_r + 4'h1;
                        if (half_cnt_r == `SPISS_LAST_EDGE) begin
                            m_state_r <= ST_IDLE;
                        end
                    end else begin
                        div_cnt_r <= div_cnt_r + 5'h01;
                    end
                end
                default: begin
                    m_state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // slave edge counter, restarts whenever select is released
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slv_cnt_r <= 4'h0;
        end else if (~s_act) begin
            slv_cnt_r <= 4'h0;
        end else if (s_lead | s_trail) begin
            slv_cnt_r <= slv_cnt_r + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // shifters: writes go straight into the transmit shifter
    // ------------------------------------------------------------------
    always @* begin
        tx_sh_nxt = tx_sh_r;
        rx_sh_nxt = rx_sh_r;
        if (load) begin
            tx_sh_nxt = pwdata[7:0];
        end else if (shift_ev) begin
            tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
        end
        if (samp_ev) begin
            rx_sh_nxt = {rx_sh_r[6:0], in_bit};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sh_r  <= `SPISS_DR_RST;
            rx_sh_r  <= `SPISS_DR_RST;
            rx_buf_r <= `SPISS_DR_RST;
        end else begin
            tx_sh_r <= tx_sh_nxt;
            rx_sh_r <= rx_sh_nxt;
            // buffer keeps the unclaimed byte when an overrun occurs
            if (done_ev & ~tcf_r) begin
                rx_buf_r <= rx_sh_nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // pin drivers and interrupt level
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mosi_o  <= 1'b0;
            mosi_oe <= 1'b0;
            miso_o  <= 1'b0;
            miso_oe <= 1'b0;
            sck_oe  <= 1'b0;
            irq     <= 1'b0;
        end else begin
            mosi_o  <= tx_sh_nxt[7];
            miso_o  <= tx_sh_nxt[7];
            mosi_oe <= m_on & ~fault_ev & ~odis;
            miso_oe <= s_act & ~odis;
            sck_oe  <= m_on & ~fault_ev;
            irq     <= cr_r[`SPISS_CR_IRQEN] & (tcf_r | ovrn_r | mflt_r);
        end
    end
endmodule // spiss_top
`default_nettype wire

// >>> test/spiss_properties.sv
// port-level checks for the serial select/status block
`timescale 1ns/1ps
`default_nettype none
module spiss_properties (
    input wire logic        pclk,    // bus clock
    input wire logic        presetn, // reset, active low
    input wire logic        psel,    // apb select
    input wire logic        penable, // apb access phase
    input wire logic        pwrite,  // apb direction
    input wire logic [7:0]  paddr,   // byte address
    input wire logic [31:0] pwdata,  // write data
    input wire logic [3:0]  pstrb,   // byte strobes
    input wire logic [31:0] prdata,  // read data
    input wire logic        pready,  // ready
    input wire logic        pslverr, // error answer
    input wire logic        sck_o,   // link clock out
    input wire logic        mosi_oe, // master-out enable
    input wire logic        miso_oe, // master-in enable
    input wire logic        irq      // interrupt level
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // --------
    // bus answer
    // --------
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    bad_addr_err_a: assert property (pready && !pwrite && paddr != 8'h00 && paddr != 8'h04
        && paddr != 8'h08 |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    // --------
    // status and pins
    // --------
    status_reserved_a: assert property (pready && !pwrite && paddr == 8'h00 |->
        prdata[3] == 1'b0 && prdata[31:8] == 24'h00_0000) else $error("reserved status bit set");
    flags_irq_a: assert property (pready && !pwrite && paddr == 8'h00 &&
        prdata[7:4] == 4'h0 |-> !irq) else $error("irq without flag");
    out_disable_a: assert property (psel && penable && pready && pwrite && pstrb[0] &&
        paddr == 8'h00 && pwdata[2] |-> ##[1:3] !mosi_oe && !miso_oe)
        else $error("output not disabled");
    one_driver_a: assert property (!(mosi_oe && miso_oe))
        else $error("both data outputs driven");
    sck_hold_a: assert property ($changed(sck_o) |=> $stable(sck_o))
        else $error("link clock half period too short");
endmodule // spiss_properties
bind spiss_top spiss_properties u_prop (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .sck_o, .mosi_oe, .miso_oe, .irq);
`default_nettype wire

// >>> test/spiss_peer_model.sv
// external slave device on the link, clock phase 0, msb first
`timescale 1ns/1ps
`default_nettype none
module spiss_peer_model (
    input  wire logic       sck,   // link clock from master
    input  wire logic       mosi,  // data from master
    input  wire logic       sel_n, // select, active low
    input  wire logic [7:0] tx,    // reply byte
    output var  logic       miso,  // data to master
    output var  logic [7:0] rx,    // last byte taken in
    output var  int         n_rx   // bytes taken in
);
    logic [7:0] sh, rsh;  // held reply, incoming bits
    logic [2:0] b, oi;    // bits sampled, bits sent
    logic       drv, hold; // live bit, last driven bit
    initial begin
        {b, oi, sh, rsh, rx, hold} = '0;
        n_rx = 0;
    end
    // sample on the leading edge
    always @(posedge sck) begin
        if (!sel_n) begin
            if (b == 3'd0) sh <= tx;
            rsh <= {rsh[6:0], mosi};
            if (b == 3'd7) begin
                rx <= {rsh[6:0], mosi};
                n_rx <= n_rx + 1;
            end
            b <= b + 3'd1;
        end
    end
    // next bit leaves on the trailing edge
    always @(negedge sck) oi <= b;
    always_comb drv = (oi == 3'd0) ? tx[7] : sh[3'd7 - oi];
    always @(drv or sel_n) if (!sel_n) hold = drv;
    // released line shows the inverse, so a stale bit cannot pass
    always_comb miso = sel_n ? ~hold : drv;
endmodule // spiss_peer_model
`default_nettype wire

// >>> test/tb_spi_slave_select_status_data.sv
// self-checking bench for the serial select/status block
`timescale 1ns/1ps
`default_nettype none
module tb_spi_slave_select_status_data;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err; // bus
    logic [7:0]  paddr, peer_tx, peer_rx;        // address, peer bytes
    logic [31:0] pwdata, prdata, rd;             // bus data
    logic [3:0]  pstrb;                          // strobes
    logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq; // outputs
    logic        sck_b, mosi_b, ss_n, peer_sel_n, peer_miso; // link drivers
    int          n_mismatch, n_checks, n_rx, cyc, n; // counters
    wire logic   sck_w = sck_oe ? sck_o : sck_b;         // resolved clock
    wire logic   mosi_w = mosi_oe ? mosi_o : mosi_b;     // resolved master-out
    wire logic   miso_w = miso_oe ? miso_o : peer_miso;  // resolved master-in
    spiss_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .sck_i(sck_w), .sck_o, .sck_oe, .mosi_i(mosi_w), .mosi_o,
        .mosi_oe, .miso_i(miso_w), .miso_o, .miso_oe, .ss_n_i(ss_n), .irq);
    spiss_peer_model u_peer (.sck(sck_w), .mosi(mosi_w), .sel_n(peer_sel_n), .tx(peer_tx),
        .miso(peer_miso), .rx(peer_rx), .n_rx);
    // --------
    // clock, hang guard, helpers
    // --------
    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task complete_run;
        if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until ready is seen
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, wr, a, wd, 4'h1};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1); // only the bench timeout ends a hung wait
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task idle(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task wait_irq;
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 400) begin
            @(posedge pclk);
            k++;
        end
    endtask
    // --------
    // scenarios
    // --------
    task t_reset_map;
        apb(0, 8'h00, 0); chk(rd, 32'h0000_0000);
        apb(0, 8'h0C, 0); chk({err, rd[30:0]}, 32'h8000_0000);
        apb(1, 8'h00, 32'h0000_00FF); apb(0, 8'h00, 0); chk(rd, 32'h0000_0007);
    endtask
    task t_master;
        peer_tx <= 8'h3C;
        apb(1, 8'h00, 32'h0000_0003);
        apb(1, 8'h08, 32'h0000_00D1);
        apb(1, 8'h04, 32'h0000_00A5); wait_irq(); chk(peer_rx, 32'h0000_00A5);
        apb(0, 8'h00, 0); chk(rd, 32'h0000_0083);
        apb(0, 8'h04, 0); chk(rd, 32'h0000_003C);
        apb(0, 8'h00, 0); chk(rd, 32'h0000_0003);
    endtask
    task t_collide_block;
        peer_tx <= 8'h96;
        apb(1, 8'h04, 32'h0000_0011);
        apb(1, 8'h04, 32'h0000_0022); wait_irq(); chk(peer_rx, 32'h0000_0011);
        n = n_rx;
        apb(1, 8'h04, 32'h0000_0033); idle(40); chk(n_rx, n);
        apb(0, 8'h00, 0); chk(rd, 32'h0000_00C3);
        apb(0, 8'h04, 0); chk(rd, 32'h0000_0096);
        apb(0, 8'h00, 0); chk(rd, 32'h0000_0003);
    endtask
    task t_out_disable;
        apb(1, 8'h00, 32'h0000_0007); idle(3); chk(mosi_oe, 0);
        apb(1, 8'h00, 32'h0000_0003); idle(3); chk(mosi_oe, 1);
    endtask
    task t_fault;
        apb(1, 8'h00, 32'h0000_0000);
        ss_n <= 1'b0;
        idle(8);
        ss_n <= 1'b1;
        idle(8); chk(irq, 1);
        apb(1, 8'h08, 32'h0000_00D1); apb(0, 8'h00, 0); chk(rd, 32'h0000_0010);
        apb(1, 8'h08, 32'h0000_00D1); apb(0, 8'h00, 0); chk(rd, 32'h0000_0000);
    endtask
    // slave, phase 1, selected by software while the pin stays high
    task t_slave;
        apb(1, 8'h08, 32'h0000_0044);
        apb(1, 8'h00, 32'h0000_0002);
        for (int i = 7; i >= 0; i--) begin
            {sck_b, mosi_b} <= {1'b1, 1'(8'hC7 >> i)};
            idle(4);
            sck_b <= 1'b0;
            idle(4);
        end
        idle(8);
        apb(0, 8'h00, 0); chk(rd, 32'h0000_0082);
        apb(0, 8'h04, 0); chk(rd, 32'h0000_00C7);
    endtask
    // slave, phase 0: a write while selected collides, after release it does not
    task t_slave_ph0;
        apb(1, 8'h08, 32'h0000_0040); apb(1, 8'h00, 32'h0000_0002);
        apb(1, 8'h04, 32'h0000_0055); apb(1, 8'h00, 32'h0000_0003);
        apb(0, 8'h00, 0); chk(rd, 32'h0000_0043);
        apb(1, 8'h04, 32'h0000_0066); apb(0, 8'h00, 0); chk(rd, 32'h0000_0003);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {sck_b, mosi_b, peer_sel_n, peer_tx, ss_n} = {11'h000, 1'b1};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_map();
        t_master();
        t_collide_block();
        t_out_disable();
        t_fault();
        t_slave();
        t_slave_ph0();
        complete_run();
    end
endmodule // tb_spi_slave_select_status_data
`default_nettype wire
